// *** pkg/clss_cfg.svh ***
// Constants for the closed loop stepper supervisor
`ifndef CLSS_CFG_SVH
`define CLSS_CFG_SVH
`define CLSS_POS_W        32
`define CLSS_ATT_W        8
`define CLSS_DLY_W        24
`define CLSS_MODE_IGNORE  2'h0
`define CLSS_MODE_STOP    2'h1
`define CLSS_MODE_CORRECT 2'h2
`define CLSS_MODE_RESTART 2'h3
`define CLSS_EDGES_LINE   4
`endif

// *** pkg/clss_pkg.sv ***
// Types for the closed loop stepper supervisor
`include "clss_cfg.svh"
package clss_pkg;
   typedef enum logic [4:0]
   {
      ST_IDLE   = 5'h01,
      ST_MOVE   = 5'h02,
      ST_SETTLE = 5'h04,
      ST_CORR   = 5'h08,
      ST_FAULT  = 5'h10
   } clss_state_e;

   typedef struct packed
   {
      logic [1:0]                 mode;
      logic                       reverse;
      logic [`CLSS_POS_W-1:0]     motion_error_limit;
      logic [`CLSS_POS_W-1:0]     standstill_band;
      logic [`CLSS_ATT_W-1:0]     max_attempts;
      logic [`CLSS_DLY_W-1:0]     settle_cycles;
   } clss_cfg_s;
endpackage

// *** hw/clss_supervisor.sv ***
// Closed loop stepper supervisor for one axis
`timescale 1ns/100ps
`default_nettype none
`include "clss_cfg.svh"

// Functional notes
// - Every quadrature edge counts, four counts per encoder line; edges on both phases in one sample do not count.
// - Reverse direction setting inverts the sign of decoded counts.
// - Stall when motion error magnitude exceeds the motion limit.
// - At standstill, error beyond the standstill band requests correction in mode 2.
// - Mode 0 ignores stalls, running open loop.
// - Mode 1 stops the motor, flags controller error and lights fault.
// - Mode 2 issues corrective moves up to the attempt limit.
// - Mode 2 still misaligned after the limit stops and flags error.
// - Mode 3 returns to move start and repeats the move.
// - Mode 3 counts each restart; reaching limit flags error and fault.
// - Attempt limit counts consecutive attempts from first stall to arrival.
// - Wait the settle time between successive attempts.
// - Mode input is live and takes effect immediately.
// - Boost output asserts only during motion when boost enabled.
// - Nonzero boost setting enables, zero disables, per axis.
// - Error is commanded position minus feedback position.
module clss_supervisor #(
   parameter int POS_W = `CLSS_POS_W,
   parameter int ATT_W = `CLSS_ATT_W,
   parameter int DLY_W = `CLSS_DLY_W
)(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   // Encoder pins
   input  wire logic                enc_a,
   input  wire logic                enc_b,
   // Configuration
   input  wire clss_pkg::clss_cfg_s cfg,
   input  wire logic [7:0]          boost_setting,
   // Motion interface from trajectory logic
   input  wire logic                move_start,
   input  wire logic                in_motion,
   input  wire logic [POS_W-1:0]    commanded_position,
   input  wire logic [POS_W-1:0]    move_start_position,
   input  wire logic                fault_clear,
   // Outputs
   output logic [POS_W-1:0]         feedback_position,
   output logic                     stop_req,
   output logic                     correct_req,
   output logic                     restart_req,
   output logic                     ctrl_error,
   output logic                     fault_light,
   output logic                     boost_out,
   output logic [ATT_W-1:0]         attempt_count
);

   //--------------------------------------------------------------
   // Encoder synchroniser and decode
   //--------------------------------------------------------------
   logic [2:0] a_sync_reg;
   logic [2:0] b_sync_reg;
   logic [1:0] ab_prev_reg;
   logic       a_lvl_reg;
   logic       b_lvl_reg;
   wire  [1:0] ab_now = {a_lvl_reg, b_lvl_reg};
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         a_sync_reg  <= 3'h0;
         b_sync_reg  <= 3'h0;
         ab_prev_reg <= 2'h0;
      end
      else
      begin
         a_sync_reg  <= {a_sync_reg[1:0], enc_a};
         b_sync_reg  <= {b_sync_reg[1:0], enc_b};
         ab_prev_reg <= ab_now;
      end

   // Level accepted once stages two and three agree
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         a_lvl_reg <= 1'h0;
         b_lvl_reg <= 1'h0;
      end
      else
      begin
         if (a_sync_reg[1] == a_sync_reg[2]) a_lvl_reg <= a_sync_reg[2];
         if (b_sync_reg[1] == b_sync_reg[2]) b_lvl_reg <= b_sync_reg[2];
      end

   wire       a_chg    = ab_now[1] ^ ab_prev_reg[1];
   wire       b_chg    = ab_now[0] ^ ab_prev_reg[0];
   wire       one_step = a_chg ^ b_chg;
   wire       fwd_raw  = ab_prev_reg[1] ^ ab_now[0];
   wire       fwd      = fwd_raw ^ cfg.reverse;

   logic [POS_W-1:0] fb_next;
   assign fb_next = !one_step ? feedback_position :
                    fwd ? feedback_position + POS_W'(1) : feedback_position - POS_W'(1);
   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         feedback_position <= '0;
      else
         feedback_position <= fb_next;

   //--------------------------------------------------------------
   // Error compare
   //--------------------------------------------------------------
   wire [POS_W-1:0] pos_err  = commanded_position - feedback_position;
   wire [POS_W-1:0] err_mag  = pos_err[POS_W-1] ? (~pos_err + POS_W'(1)) : pos_err;
   wire             stall    = in_motion && (err_mag > cfg.motion_error_limit);
   wire             out_band = err_mag > cfg.standstill_band;
   wire             at_limit = attempt_count >= cfg.max_attempts;

   //--------------------------------------------------------------
   // Supervisor state machine
   //--------------------------------------------------------------
   clss_pkg::clss_state_e state_reg;
   clss_pkg::clss_state_e state_next;
   logic [DLY_W-1:0]      dly_reg;
   logic [ATT_W-1:0]      att_next;
   logic                  stop_next;
   logic                  corr_next;
   logic                  rst_next;

   always_comb
   begin
      state_next = state_reg;
      att_next   = attempt_count;
      stop_next  = 1'b0;
      corr_next  = 1'b0;
      rst_next   = 1'b0;
      case (state_reg)
         clss_pkg::ST_IDLE:
            if (move_start)
            begin
               att_next   = '0;
               state_next = clss_pkg::ST_MOVE;
            end
            else if (!in_motion && out_band && cfg.mode == `CLSS_MODE_CORRECT)
            begin
               // Standstill drift needs correcting
               state_next = clss_pkg::ST_SETTLE;
            end
         clss_pkg::ST_MOVE:
            if (move_start)
               att_next = '0;
            else if (stall)
            begin
               case (cfg.mode)
                  `CLSS_MODE_IGNORE: state_next = clss_pkg::ST_MOVE;
                  `CLSS_MODE_STOP:
                  begin
                     stop_next  = 1'b1;
                     state_next = clss_pkg::ST_FAULT;
                  end
                  default:
                  begin
                     stop_next  = 1'b1;
                     state_next = clss_pkg::ST_SETTLE;
                  end
               endcase
            end
            else if (!in_motion)
            begin
               if (!out_band)
               begin
                  att_next   = '0;
                  state_next = clss_pkg::ST_IDLE;
               end
               else if (cfg.mode == `CLSS_MODE_CORRECT || cfg.mode == `CLSS_MODE_RESTART)
                  state_next = clss_pkg::ST_SETTLE;
               else
                  state_next = clss_pkg::ST_IDLE;
            end
         clss_pkg::ST_SETTLE:
            if (cfg.mode == `CLSS_MODE_IGNORE)
               state_next = clss_pkg::ST_IDLE;
            else if (dly_reg == '0)
            begin
               if (!in_motion && !out_band)
               begin
                  att_next   = '0;
                  state_next = clss_pkg::ST_IDLE;
               end
               else if (at_limit)
               begin
                  stop_next  = 1'b1;
                  state_next = clss_pkg::ST_FAULT;
               end
               else
               begin
                  att_next   = attempt_count + ATT_W'(1);
                  corr_next  = (cfg.mode != `CLSS_MODE_RESTART);
                  rst_next   = (cfg.mode == `CLSS_MODE_RESTART);
                  state_next = clss_pkg::ST_CORR;
               end
            end
         clss_pkg::ST_CORR:
            if (in_motion)
               state_next = clss_pkg::ST_MOVE;
         clss_pkg::ST_FAULT:
            if (fault_clear)
               state_next = clss_pkg::ST_IDLE;
         default:
            state_next = clss_pkg::ST_IDLE;
      endcase
   end

   wire load_dly = (state_next == clss_pkg::ST_SETTLE) && (state_reg != clss_pkg::ST_SETTLE);
   wire fault_on = (state_next == clss_pkg::ST_FAULT);

   always_ff @(posedge core_clk or negedge rst_b)
      if (!rst_b)
      begin
         state_reg     <= clss_pkg::ST_IDLE;
         dly_reg       <= '0;
         attempt_count <= '0;
         stop_req      <= 1'b0;
         correct_req   <= 1'b0;
         restart_req   <= 1'b0;
         ctrl_error    <= 1'b0;
         fault_light   <= 1'b0;
         boost_out     <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         attempt_count <= att_next;
         stop_req      <= stop_next;
         correct_req   <= corr_next;
         restart_req   <= rst_next;
         ctrl_error    <= fault_on;
         fault_light   <= fault_on;
         boost_out     <= in_motion && (boost_setting != 8'h00);
         if (load_dly)
            dly_reg <= cfg.settle_cycles;
         else if (dly_reg != '0)
            dly_reg <= dly_reg - DLY_W'(1);
      end

   //--------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_stop_stall;
      state_reg == clss_pkg::ST_MOVE && !move_start && stall && cfg.mode == `CLSS_MODE_STOP;
   endsequence

   AST_STOP_FAULT: assert property (s_stop_stall |=> stop_req && fault_light && ctrl_error)
      else $error("stop mode stall did not fault");
   AST_IGNORE: assert property (state_reg == clss_pkg::ST_MOVE && cfg.mode == `CLSS_MODE_IGNORE
      |=> !stop_req)
      else $error("ignore mode stopped motor");
   AST_BOOST: assert property (!in_motion |=> !boost_out)
      else $error("boost active at standstill");
   AST_BOOST_ON: assert property (in_motion && boost_setting != 8'h00 |=> boost_out)
      else $error("boost not driven");
   AST_RESTART: assert property (restart_req |-> $past(cfg.mode) == `CLSS_MODE_RESTART)
      else $error("restart in wrong mode");
   AST_CORR: assert property (correct_req |-> attempt_count == $past(attempt_count) + ATT_W'(1))
      else $error("correction not counted");
   AST_SETTLE: assert property ($rose(state_reg == clss_pkg::ST_SETTLE) && cfg.settle_cycles > 1
      |=> !correct_req && !restart_req)
      else $error("attempt without settle");
   AST_NEWMOVE: assert property (move_start && state_reg != clss_pkg::ST_FAULT
      && state_reg != clss_pkg::ST_SETTLE && state_reg != clss_pkg::ST_CORR |=> attempt_count == '0)
      else $error("counter not cleared on move");
   AST_DOUBLE: assert property (a_chg && b_chg |=> feedback_position == $past(feedback_position))
      else $error("double phase change counted");
endmodule
`default_nettype wire

// *** bench/clss_enc_model.sv ***
// Shaft encoder model turning step pulses into quadrature phases
`timescale 1ns/100ps
`default_nettype none
module clss_enc_model (
   // Clock
   input  wire logic core_clk,
   // Step requests
   input  wire logic step_fwd,
   input  wire logic step_rev,
   input  wire logic step_skip,
   // Encoder phases
   output logic      enc_a,
   output logic      enc_b
);
   logic [1:0] ph_reg = 2'h0;
   always @(posedge core_clk)
   begin
      if (step_fwd)
         ph_reg <= ph_reg + 2'h1;
      else if (step_rev)
         ph_reg <= ph_reg - 2'h1;
      // Illegal jump: both phases change in one step
      else if (step_skip)
         ph_reg <= ph_reg + 2'h2;
   end
   // Gray order: one phase changes per step, four steps per line
   assign enc_a = ph_reg[1];
   assign enc_b = ph_reg[1] ^ ph_reg[0];
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking testbench for the closed loop stepper supervisor
`timescale 1ns/100ps
`default_nettype none
`include "clss_cfg.svh"
module testbench;
   logic core_clk = 1'b0, rst_b = 1'b0, step_fwd = 1'b0, step_rev = 1'b0, step_skip = 1'b0;
   logic enc_a, enc_b, move_start = 1'b0, in_motion = 1'b0, fault_clear = 1'b0;
   logic stop_req, correct_req, restart_req, ctrl_error, fault_light, boost_out;
   logic [7:0] boost_setting = 8'h00, attempt_count;
   logic [31:0] commanded_position = 32'h0, feedback_position, pos = 32'h0;
   clss_pkg::clss_cfg_s cfg = '0;
   int fails = 0, compares = 0, n;
   always #12.5 core_clk = ~core_clk;
   clss_enc_model i_enc (.core_clk(core_clk), .step_fwd(step_fwd), .step_rev(step_rev),
      .step_skip(step_skip), .enc_a(enc_a), .enc_b(enc_b));
   clss_supervisor i_dut (.core_clk(core_clk), .rst_b(rst_b), .enc_a(enc_a), .enc_b(enc_b),
      .cfg(cfg), .boost_setting(boost_setting), .move_start(move_start),
      .in_motion(in_motion), .commanded_position(commanded_position),
      .move_start_position(32'h0), .fault_clear(fault_clear),
      .feedback_position(feedback_position), .stop_req(stop_req),
      .correct_req(correct_req), .restart_req(restart_req), .ctrl_error(ctrl_error),
      .fault_light(fault_light), .boost_out(boost_out), .attempt_count(attempt_count));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_sig(input int w, output int k);
      logic s;
      k = 0;
      do
      begin
         @(negedge core_clk);
         k++;
         s = (w == 0) ? stop_req : (w == 1) ? correct_req : (w == 2) ? restart_req : ctrl_error;
      end while (s !== 1'b1 && k < 60);
      chk("wait", 1'b1, s);
      if (s !== 1'b1)
         end_sim();
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask
   task automatic steps(input int k, input logic fwd);
      repeat (k)
      begin
         if (fwd) pulse(step_fwd); else pulse(step_rev);
         repeat (5) @(negedge core_clk);
      end
   endtask
   task automatic recover();
      pulse(fault_clear);
      in_motion = 1'b0;
      commanded_position = pos;
      repeat (4) @(negedge core_clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_count();
      steps(12, 1'b1);
      chk("fwd", 32'd12, feedback_position);
      steps(4, 1'b0);
      chk("rev", 32'd8, feedback_position);
      cfg.reverse = 1'b1;
      steps(4, 1'b1);
      chk("inv", 32'd4, feedback_position);
      pulse(step_skip);
      repeat (6) @(negedge core_clk);
      chk("skip", 32'd4, feedback_position);
      pos = 32'd4;
      commanded_position = pos;
      $display("test count done");
   endtask
   task automatic t_modes01();
      cfg.motion_error_limit = 32'd50;
      commanded_position = pos + 32'd100;
      pulse(move_start);
      in_motion = 1'b1;
      n = 0;
      repeat (10) @(negedge core_clk) n += stop_req | ctrl_error;
      chk("ignore", 0, n);
      cfg.mode = `CLSS_MODE_STOP;
      commanded_position = pos + 32'd50;
      repeat (6) @(negedge core_clk);
      chk("at_limit", 1'b0, ctrl_error);
      commanded_position = pos + 32'd51;
      wait_sig(0, n);
      chk("fault", 1'b1, fault_light & ctrl_error);
      recover();
      chk("cleared", 1'b0, fault_light);
      $display("test modes 0 1 done");
   endtask
   task automatic t_correct();
      cfg.mode = `CLSS_MODE_CORRECT;
      cfg.max_attempts = 8'h02;
      cfg.settle_cycles = 24'h4;
      commanded_position = pos - 32'd60;
      pulse(move_start);
      in_motion = 1'b1;
      for (int i = 1; i <= 2; i++)
      begin
         wait_sig(0, n);
         wait_sig(1, n);
         chk("settle", cfg.settle_cycles + 32'd1, n);
         chk("attempts", i, attempt_count);
      end
      wait_sig(3, n);
      recover();
      $display("test correct done");
   endtask
   task automatic t_restart();
      cfg.max_attempts = 8'h01;
      commanded_position = pos + 32'd60;
      pulse(move_start);
      in_motion = 1'b1;
      cfg.mode = `CLSS_MODE_RESTART;
      wait_sig(2, n);
      chk("restarts", 1, attempt_count);
      wait_sig(3, n);
      chk("light", 1'b1, fault_light);
      recover();
      pulse(move_start);
      repeat (2) @(negedge core_clk);
      chk("cleared", 0, attempt_count);
      $display("test restart done");
   endtask
   task automatic t_boost();
      cfg.mode = `CLSS_MODE_IGNORE;
      in_motion = 1'b1;
      repeat (3) @(negedge core_clk);
      chk("boost_off", 1'b0, boost_out);
      boost_setting = 8'h80;
      repeat (3) @(negedge core_clk);
      chk("boost_on", 1'b1, boost_out);
      in_motion = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("boost_idle", 1'b0, boost_out);
      $display("test boost done");
   endtask
   task automatic t_drift();
      cfg.mode = `CLSS_MODE_CORRECT;
      cfg.standstill_band = 32'd2;
      commanded_position = pos + 32'd2;
      n = 0;
      repeat (8) @(negedge core_clk) n += correct_req | stop_req;
      chk("in_band", 0, n);
      commanded_position = pos + 32'd3;
      wait_sig(1, n);
      chk("drift_att", 1, attempt_count);
      in_motion = 1'b1;
      steps(3, 1'b0);
      in_motion = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("drift_pos", pos + 32'd3, feedback_position);
      chk("drift_clr", 0, attempt_count);
      $display("test drift done");
   endtask
   initial
   begin
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      t_count();
      t_modes01();
      t_correct();
      t_restart();
      t_boost();
      t_drift();
      end_sim();
   end
endmodule
`default_nettype wire
